// ### hw/current_channel_fault_select.sv
// current_channel_fault_select: two-input current fault detection and channel routing
//
// Implementation choice: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module current_channel_fault_select
  import fault_select_pkg::*;
#(
  parameter longint SETTLE = SETTLE_CYCLES,
  parameter int     AVG_SHIFT = 10
) (
  // clock and reset
  input  wire logic                            clock,
  input  wire logic                            rst,
  // apb slave
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [11:0]                     paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  // adc sample streams
  input  wire logic                            sampleValid,
  input  wire fault_select_pkg::sample_pair_type samples,
  input  wire logic [SAMPLE_WIDTH-1:0]         voltageLevel,
  // selected current for power and rms
  output logic      [SAMPLE_WIDTH-1:0]         selectedCurrent,
  output logic                                 selectedValid,
  output logic                                 irq
);
  initial begin
    if (SETTLE < 1) $error("current_channel_fault_select: SETTLE must be positive");
  end
  localparam logic [31:0] SETTLE_W = 32'(SETTLE);

  logic [7:0]            accumulation_mode_reg;
  logic [7:0]            calibration_mode_reg;
  logic [7:0]            irqEn_reg;
  logic [7:0]            irqSt_reg;
  logic [TRIM_WIDTH-1:0] trim_reg;
  logic                  selSecond_reg;
  logic                  inFault_reg;
  logic [31:0]           settle_reg;
  route_state_type       state_reg;
  logic                  sv1_reg;
  logic                  sv2_reg;
  sample_pair_type       s1_reg;
  sample_pair_type       s2_reg;
  logic [SAMPLE_WIDTH-1:0] v1_reg;
  logic [SAMPLE_WIDTH-1:0] v2_reg;

  // adc sample stream inputs pass two flops before use
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      sv1_reg <= 1'b0;
      sv2_reg <= 1'b0;
      s1_reg  <= '0;
      s2_reg  <= '0;
      v1_reg  <= '0;
      v2_reg  <= '0;
    end else begin
      sv1_reg <= sampleValid;
      sv2_reg <= sv1_reg;
      s1_reg  <= samples;
      s2_reg  <= s1_reg;
      v1_reg  <= voltageLevel;
      v2_reg  <= v1_reg;
    end
  end

  logic                    trimValid;
  logic [SAMPLE_WIDTH-1:0] secondTrimmed;
  logic [SAMPLE_WIDTH-1:0] firstDelayed;
  gain_trim #(.WIDTH(SAMPLE_WIDTH), .TRIM(TRIM_WIDTH)) trimUnit (
    .clock     (clock),
    .rst       (rst),
    .inValid   (sv2_reg),
    .inSample  (s2_reg.second),
    .trim      (trim_reg),
    .outValid  (trimValid),
    .outSample (secondTrimmed)
  );
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      firstDelayed <= '0;
    end else begin
      firstDelayed <= s2_reg.first;
    end
  end

  logic [SAMPLE_WIDTH-1:0] avgFirst;
  logic [SAMPLE_WIDTH-1:0] avgSecond;
  logic                    avgValid;
  magnitude_average #(.WIDTH(SAMPLE_WIDTH), .SHIFT(AVG_SHIFT)) avgA (
    .clock        (clock),
    .rst          (rst),
    .sampleValid  (trimValid),
    .sample       (firstDelayed),
    .average      (avgFirst),
    .averageValid (avgValid)
  );
  magnitude_average #(.WIDTH(SAMPLE_WIDTH), .SHIFT(AVG_SHIFT)) avgB (
    .clock        (clock),
    .rst          (rst),
    .sampleValid  (trimValid),
    .sample       (secondTrimmed),
    .average      (avgSecond),
    .averageValid ()
  );

  // thresholds at 1/16 of the reference channel
  logic [SAMPLE_WIDTH:0] aW, bW, sixteenthA, sixteenthB;
  logic firstActive, faultNow, swapToSecond, swapToFirst, firstLow, withinMode;
  logic voltageOk;
  logic [39:0] vScaled, vFloor;
  assign aW         = {1'b0, avgFirst};
  assign bW         = {1'b0, avgSecond};
  assign sixteenthA = aW >> 4;
  assign sixteenthB = bW >> 4;
  assign firstActive = !selSecond_reg;
  assign firstLow     = firstActive && (bW + sixteenthA < aW);
  // second exceeds first by more than 1/16 of second
  assign swapToSecond = firstActive && (bW > aW + sixteenthB);
  // first exceeds second by more than 1/16 of second
  assign swapToFirst  = !firstActive && (aW > bW + sixteenthB);
  // difference beyond 1/16 of the active channel
  assign faultNow = firstActive ? ((aW > bW + sixteenthA) || (bW > aW + sixteenthA))
                                : ((aW > bW + sixteenthB) || (bW > aW + sixteenthB));
  assign withinMode = (aW + sixteenthB >= bW) && (bW + sixteenthB >= aW);
  // voltage floor at 3/1000 of full scale
  assign vScaled   = 40'(v2_reg[SAMPLE_WIDTH-1] ? SAMPLE_WIDTH'(-v2_reg) : v2_reg) * 40'd1000;
  assign vFloor    = 40'(VOLT_FULL_SCALE) * 40'(VOLT_FLOOR_PERMILLE);
  assign voltageOk = vScaled >= vFloor;

  logic [1:0] force_sel;
  assign force_sel = calibration_mode_reg[FORCE_LO_BIT +: 2];
  logic wantSecond, decide, faultEvent, apbWrite, apbRead;
  always_comb begin
    wantSecond = selSecond_reg;
    if (swapToSecond) begin
      wantSecond = 1'b1;
    end else if (swapToFirst) begin
      wantSecond = 1'b0;
    end
  end
  // decisions only after the condition settled
  assign decide = avgValid && voltageOk && (settle_reg >= SETTLE_W);

  // settle counter: counts while the condition differs from the current state, restarts when they match, at low voltage or on a decision
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      settle_reg <= '0;
    end else if (avgValid) begin
      if (!voltageOk || decide || (faultNow == inFault_reg && wantSecond == selSecond_reg)) begin
        settle_reg <= '0;
      end else if (settle_reg < SETTLE_W) begin
        settle_reg <= settle_reg + 32'd1;
      end
    end
  end

  // routing state machine
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg     <= ST_FIRST;
      selSecond_reg <= 1'b0;
    end else begin
      case (state_reg)
        ST_FIRST, ST_SECOND: begin
          if (force_sel == FORCE_FIRST) begin
            selSecond_reg <= 1'b0;
            state_reg     <= ST_HOLD;
          end else if (force_sel == FORCE_SECOND) begin
            selSecond_reg <= 1'b1;
            state_reg     <= ST_HOLD;
          end else if (decide) begin
            selSecond_reg <= wantSecond;
            state_reg     <= wantSecond ? ST_SECOND : ST_FIRST;
          end
        end
        ST_HOLD: begin
          if (force_sel == FORCE_FIRST) begin
            selSecond_reg <= 1'b0;
          end else if (force_sel == FORCE_SECOND) begin
            selSecond_reg <= 1'b1;
          end else begin
            state_reg <= selSecond_reg ? ST_SECOND : ST_FIRST;
          end
        end
        default: begin
          state_reg     <= ST_FIRST;
          selSecond_reg <= 1'b0;
        end
      endcase
    end
  end

  // fault state tracking
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      inFault_reg <= 1'b0;
    end else if (decide) begin
      inFault_reg <= faultNow;
    end
  end

  always_comb begin
    if (accumulation_mode_reg[FLAG_MODE_BIT]) begin
      faultEvent = avgValid && voltageOk && withinMode && !selSecond_reg;
    end else begin
      faultEvent = decide && (faultNow != inFault_reg || firstLow || swapToSecond);
    end
  end

  // apb decode: zero wait states
  logic [7:0] idx;
  assign idx      = paddr[ADDR_SHIFT +: 8];
  assign apbWrite = psel && penable && pwrite;
  assign apbRead  = psel && !penable && !pwrite;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      accumulation_mode_reg <= ACC_MODE_RESET;
      calibration_mode_reg <= CAL_MODE_RESET;
      irqEn_reg   <= IRQ_EN_RESET;
      trim_reg    <= TRIM_RESET;
    end else if (apbWrite) begin
      case (idx)
        ACC_MODE_OFFSET:  accumulation_mode_reg <= {1'b0, pwdata[6:0]};
        CAL_MODE_OFFSET:  calibration_mode_reg <= pwdata[7:0];
        IRQ_EN_OFFSET:    irqEn_reg   <= pwdata[7:0];
        GAIN_TRIM_OFFSET: trim_reg    <= pwdata[TRIM_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  // status: set wins over write-one-to-clear
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irqSt_reg <= 8'h00;
    end else begin
      if (apbWrite && idx == IRQ_ST_OFFSET) begin
        irqSt_reg[FAULT_BIT] <= (irqSt_reg[FAULT_BIT] & ~pwdata[FAULT_BIT]) | faultEvent;
      end else if (faultEvent) begin
        irqSt_reg[FAULT_BIT] <= 1'b1;
      end
    end
  end

  // read data registered in setup, so pready can rise in the first access cycle
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin
      pslverr <= !(idx == ACC_MODE_OFFSET || idx == CAL_MODE_OFFSET || idx == IRQ_EN_OFFSET
                   || idx == IRQ_ST_OFFSET || idx == GAIN_TRIM_OFFSET);
      if (apbRead) begin
        case (idx)
          ACC_MODE_OFFSET:  prdata <= {24'h0, selSecond_reg, accumulation_mode_reg[6:0]};
          CAL_MODE_OFFSET:  prdata <= {24'h0, calibration_mode_reg};
          IRQ_EN_OFFSET:    prdata <= {24'h0, irqEn_reg};
          IRQ_ST_OFFSET:    prdata <= {24'h0, irqSt_reg};
          GAIN_TRIM_OFFSET: prdata <= {20'h0, trim_reg};
          default:          prdata <= 32'h0;
        endcase
      end
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
    end else begin
      pready <= psel && !penable;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irqSt_reg & irqEn_reg);
    end
  end

  // selected current routed to power and rms
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      selectedCurrent <= '0;
      selectedValid   <= 1'b0;
    end else begin
      selectedValid   <= trimValid;
      selectedCurrent <= selSecond_reg ? secondTrimmed : firstDelayed;
    end
  end

  property p_force_first;
    @(posedge clock) disable iff (rst)
    (force_sel == FORCE_FIRST) |=> !selSecond_reg;
  endproperty
  a_force_first: assert property (p_force_first) else $error("force first ignored");
  property p_force_second;
    @(posedge clock) disable iff (rst)
    (force_sel == FORCE_SECOND) |=> selSecond_reg;
  endproperty
  a_force_second: assert property (p_force_second) else $error("force second ignored");
  property p_irq;
    @(posedge clock) disable iff (rst)
    (irqSt_reg[FAULT_BIT] && irqEn_reg[FAULT_BIT]) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");
  property p_irq_low;
    @(posedge clock) disable iff (rst)
    !(|(irqSt_reg & irqEn_reg)) |=> !irq;
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("spurious irq");
  property p_flag_set;
    @(posedge clock) disable iff (rst)
    faultEvent |=> irqSt_reg[FAULT_BIT];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("fault event lost");
  property p_no_switch_low_v;
    @(posedge clock) disable iff (rst)
    (!voltageOk && force_sel != FORCE_FIRST && force_sel != FORCE_SECOND
     && state_reg != ST_HOLD) |=> $stable(selSecond_reg);
  endproperty
  a_no_switch_low_v: assert property (p_no_switch_low_v) else $error("swap at low voltage");
  property p_no_swap_first_low;
    @(posedge clock) disable iff (rst)
    (firstLow && state_reg == ST_FIRST && force_sel != FORCE_SECOND) |=> !selSecond_reg;
  endproperty
  a_no_swap_first_low: assert property (p_no_swap_first_low) else $error("bad swap");
  property p_settle;
    @(posedge clock) disable iff (rst)
    (state_reg != ST_HOLD && $changed(selSecond_reg)) |-> $past(settle_reg) >= SETTLE_W;
  endproperty
  a_settle: assert property (p_settle) else $error("swap before settle");
  property p_route;
    @(posedge clock) disable iff (rst)
    trimValid |=> selectedCurrent == ($past(selSecond_reg) ? $past(secondTrimmed)
                                                           : $past(firstDelayed));
  endproperty
  a_route: assert property (p_route) else $error("wrong current routed");
  c_swap_second: cover property (@(posedge clock) disable iff (rst) $rose(selSecond_reg));
  c_swap_first:  cover property (@(posedge clock) disable iff (rst) $fell(selSecond_reg));
  c_irq:         cover property (@(posedge clock) disable iff (rst) $rose(irq));
endmodule : current_channel_fault_select
`default_nettype wire

// ### include/fault_select_pkg.sv
// package: register map, field positions and timing for the current fault selector
package fault_select_pkg;
  localparam logic [7:0] ACC_MODE_OFFSET  = 8'h0f;
  localparam logic [7:0] GAIN_TRIM_OFFSET = 8'h1c;
  localparam logic [7:0] CAL_MODE_OFFSET  = 8'h3d;
  localparam logic [7:0] IRQ_EN_OFFSET    = 8'hd9;
  localparam logic [7:0] IRQ_ST_OFFSET    = 8'hdc;
  // byte address is four times the printed index
  localparam int ADDR_SHIFT = 2;
  localparam int SEL_IND_BIT   = 7;
  localparam int FLAG_MODE_BIT = 6;
  localparam int FORCE_LO_BIT  = 4;
  localparam int FAULT_BIT     = 5;
  localparam int TRIM_WIDTH    = 12;
  localparam int SAMPLE_WIDTH  = 24;
  localparam logic [1:0] FORCE_FIRST  = 2'b01;
  localparam logic [1:0] FORCE_SECOND = 2'b10;
  localparam logic [7:0] ACC_MODE_RESET = 8'h00;
  localparam logic [7:0] CAL_MODE_RESET = 8'h00;
  localparam logic [7:0] IRQ_EN_RESET   = 8'h00;
  localparam logic [11:0] TRIM_RESET    = 12'h000;
  // averaging settle time in milliseconds and clock rate
  localparam int SETTLE_MS   = 3000;
  localparam int CLOCK_KHZ   = 100000;
  localparam longint SETTLE_CYCLES = longint'(SETTLE_MS) * longint'(CLOCK_KHZ);
  // low-voltage floor: 0.3 percent of full scale, in thousandths
  localparam int VOLT_FLOOR_PERMILLE = 3;
  localparam logic [23:0] VOLT_FULL_SCALE = 24'h20c49b;
  typedef struct packed {
    logic [SAMPLE_WIDTH-1:0] first;
    logic [SAMPLE_WIDTH-1:0] second;
  } sample_pair_type;
  typedef struct packed {
    logic       selSecond;
    logic       inFault;
  } select_state_type;
  typedef enum logic [2:0] {
    ST_FIRST  = 3'b001,
    ST_SECOND = 3'b010,
    ST_HOLD   = 3'b100
  } route_state_type;
endpackage : fault_select_pkg

// ### hw/magnitude_average.sv
// magnitude_average: rectify a signed sample and keep a leaky running average
`timescale 1ns/100ps
`default_nettype none
module magnitude_average #(
  parameter int WIDTH = 24,
  parameter int SHIFT = 10
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // sample stream
  input  wire logic             sampleValid,
  input  wire logic [WIDTH-1:0] sample,
  // averaged magnitude
  output logic      [WIDTH-1:0] average,
  output logic                  averageValid
);
  initial begin
    if (SHIFT < 1 || SHIFT > 20) $error("magnitude_average: SHIFT out of range");
  end
  logic [WIDTH-1:0]       rectified;
  logic [WIDTH+SHIFT-1:0] acc_reg;
  assign rectified = sample[WIDTH-1] ? WIDTH'(-sample) : sample;
  // leaky integrator: acc += x - acc/2^SHIFT, average = acc/2^SHIFT
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      acc_reg <= '0;
    end else if (sampleValid) begin
      acc_reg <= acc_reg - (acc_reg >> SHIFT) + (WIDTH+SHIFT)'(rectified);
    end
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      averageValid <= 1'b0;
    end else begin
      averageValid <= sampleValid;
    end
  end
  assign average = acc_reg[WIDTH+SHIFT-1:SHIFT];
endmodule : magnitude_average
`default_nettype wire

// ### hw/gain_trim.sv
// gain_trim: scale a signed sample by (1 + trim/2^12)
`timescale 1ns/100ps
`default_nettype none
module gain_trim #(
  parameter int WIDTH = 24,
  parameter int TRIM  = 12
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // input sample and trim
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inSample,
  input  wire logic [TRIM-1:0]  trim,
  // trimmed sample
  output logic                  outValid,
  output logic      [WIDTH-1:0] outSample
);
  initial begin
    if (TRIM < 2 || TRIM > WIDTH) $error("gain_trim: TRIM out of range");
  end
  logic signed [WIDTH+TRIM:0] product;
  logic signed [WIDTH+TRIM:0] sum;
  assign product = $signed(inSample) * $signed(trim);
  assign sum     = product >>> TRIM;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      outSample <= '0;
      outValid  <= 1'b0;
    end else begin
      outValid  <= inValid;
      // saturation is not needed: trim stays within -50..+50 percent
      outSample <= WIDTH'($signed(inSample) + sum);
    end
  end
endmodule : gain_trim
`default_nettype wire

// ### bench/adc_pair_model.sv
// adc_pair_model: two current adc channels giving square waves of a set magnitude
`timescale 1ns/100ps
`default_nettype none
module adc_pair_model (
  // clock and reset
  input  wire logic                              clock,
  input  wire logic                              rst,
  // wanted magnitudes
  input  wire logic [23:0]                       firstAmp,
  input  wire logic [23:0]                       secondAmp,
  // sample stream
  output logic                                   sampleValid,
  output var fault_select_pkg::sample_pair_type  samples
);
  import fault_select_pkg::*;
  logic [2:0] tick;
  logic       neg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick <= 3'h0;
      neg <= 1'b0;
      sampleValid <= 1'b0;
      samples <= '0;
    end else begin
      tick <= tick + 3'h1;
      sampleValid <= (tick == 3'h7);
      if (tick == 3'h7) begin
        neg <= ~neg;
        samples.first <= neg ? -firstAmp : firstAmp;
        samples.second <= neg ? -secondAmp : secondAmp;
      end else begin
        // off the pulse the lines toggle, so a stale sample is never mistaken for data
        samples <= ~samples;
      end
    end
  end
endmodule : adc_pair_model
`default_nettype wire

// ### bench/current_channel_fault_select_test.sv
// current_channel_fault_select_test: self-checking bench for the current fault selector
`timescale 1ns/100ps
`default_nettype none
module current_channel_fault_select_test;
  import fault_select_pkg::*;
  logic            clock, rst, psel, penable, pwrite, pready, pslverr;
  logic            sampleValid, selectedValid, irq, err;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, rd;
  sample_pair_type samples;
  logic [23:0]     voltageLevel, selectedCurrent, firstAmp, secondAmp, amp, m;
  int              bad_count, comparisons, cycles, seed;
  logic [7:0]      regs [5];

  current_channel_fault_select #(.SETTLE(4), .AVG_SHIFT(2)) uut (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sampleValid(sampleValid), .samples(samples), .voltageLevel(voltageLevel),
    .selectedCurrent(selectedCurrent), .selectedValid(selectedValid), .irq(irq));
  adc_pair_model adc (
    .clock(clock), .rst(rst), .firstAmp(firstAmp), .secondAmp(secondAmp),
    .sampleValid(sampleValid), .samples(samples));

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task test_done;
    if (bad_count == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // read until the bit reaches the wanted value, bounded so a stuck bit still ends
  task poll(input logic [7:0] idx, input int b, input logic v);
    int n;
    n = 0;
    do begin
      apb(1'b0, idx, 32'h0);
      n++;
    end while (rd[b] !== v && n < 600);
  endtask : poll

  function automatic logic [23:0] mag(input logic [23:0] v);
    return v[23] ? -v : v;
  endfunction : mag

  // skip samples still in the pipeline from before the last change
  task sel_mag;
    repeat (3) @(posedge clock iff selectedValid === 1'b1);
    m = mag(selectedCurrent);
  endtask : sel_mag

  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      bad_count++;
      test_done;
    end
  end

  initial begin
    seed = 97470;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    voltageLevel = 24'h000000;
    firstAmp = 24'h000000;
    secondAmp = 24'h000000;
    regs = '{ACC_MODE_OFFSET, GAIN_TRIM_OFFSET, CAL_MODE_OFFSET, IRQ_EN_OFFSET, IRQ_ST_OFFSET};
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    amp = 24'h080000 + (24'($random(seed)) & 24'h07fff0);
    foreach (regs[i]) begin
      apb(1'b0, regs[i], 32'h0);
      check(rd, 32'h0);
    end
    check(32'(irq), 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b1, ACC_MODE_OFFSET, 32'h80);
    apb(1'b0, ACC_MODE_OFFSET, 32'h0);
    check(rd, 32'h0);
    apb(1'b1, GAIN_TRIM_OFFSET, 32'habc);
    apb(1'b0, GAIN_TRIM_OFFSET, 32'h0);
    check(rd, 32'habc);
    apb(1'b1, GAIN_TRIM_OFFSET, 32'h0);
    // low voltage: a large second input must not be acted on
    firstAmp <= amp;
    secondAmp <= amp + (amp >> 1);
    repeat (1500) @(posedge clock);
    apb(1'b0, ACC_MODE_OFFSET, 32'h0);
    check(32'(rd[7]), 32'h0);
    apb(1'b0, IRQ_ST_OFFSET, 32'h0);
    check(rd, 32'h0);
    voltageLevel <= 24'h100000;
    poll(ACC_MODE_OFFSET, 7, 1'b1);
    check(32'(rd[7]), 32'h1);
    apb(1'b0, IRQ_ST_OFFSET, 32'h0);
    check(32'(rd[FAULT_BIT]), 32'h1);
    check(32'(irq), 32'h0);
    apb(1'b1, IRQ_EN_OFFSET, 32'h20);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h1);
    sel_mag;
    check(32'(m), 32'(amp + (amp >> 1)));
    apb(1'b1, IRQ_ST_OFFSET, 32'h20);
    repeat (2) @(posedge clock);
    check(32'(irq), 32'h0);
    // first slightly above second: inside the hysteresis band
    firstAmp <= secondAmp + (secondAmp >> 5);
    repeat (1500) @(posedge clock);
    apb(1'b0, ACC_MODE_OFFSET, 32'h0);
    check(32'(rd[7]), 32'h1);
    firstAmp <= secondAmp + (secondAmp >> 2);
    poll(ACC_MODE_OFFSET, 7, 1'b0);
    check(32'(rd[7]), 32'h0);
    apb(1'b0, IRQ_ST_OFFSET, 32'h0);
    check(32'(rd[FAULT_BIT]), 32'h1);
    // back to normal on the first input, then the second drops below 15/16
    apb(1'b1, IRQ_ST_OFFSET, 32'h20);
    firstAmp <= amp;
    secondAmp <= amp;
    poll(IRQ_ST_OFFSET, FAULT_BIT, 1'b1);
    check(32'(rd[FAULT_BIT]), 32'h1);
    apb(1'b1, IRQ_ST_OFFSET, 32'h20);
    secondAmp <= amp - (amp >> 2);
    poll(IRQ_ST_OFFSET, FAULT_BIT, 1'b1);
    check(32'(rd[FAULT_BIT]), 32'h1);
    apb(1'b0, ACC_MODE_OFFSET, 32'h0);
    check(32'(rd[7]), 32'h0);
    // forced selection and trim, with equal inputs
    secondAmp <= amp;
    apb(1'b1, GAIN_TRIM_OFFSET, 32'h100);
    apb(1'b1, CAL_MODE_OFFSET, 32'h20);
    repeat (3) @(posedge clock);
    apb(1'b0, ACC_MODE_OFFSET, 32'h0);
    check(32'(rd[7]), 32'h1);
    sel_mag;
    check(32'(m), 32'(amp + (amp >> 4)));
    apb(1'b1, CAL_MODE_OFFSET, 32'h10);
    repeat (3) @(posedge clock);
    apb(1'b0, ACC_MODE_OFFSET, 32'h0);
    check(32'(rd[7]), 32'h0);
    sel_mag;
    check(32'(m), 32'(amp));
    apb(1'b1, CAL_MODE_OFFSET, 32'h30);
    repeat (300) @(posedge clock);
    apb(1'b0, ACC_MODE_OFFSET, 32'h0);
    check(32'(rd[7]), 32'h0);
    // flag mode set: equal inputs raise the flag
    apb(1'b1, IRQ_ST_OFFSET, 32'h20);
    apb(1'b1, ACC_MODE_OFFSET, 32'h40);
    poll(IRQ_ST_OFFSET, FAULT_BIT, 1'b1);
    check(32'(rd[FAULT_BIT]), 32'h1);
    test_done;
  end
endmodule : current_channel_fault_select_test
`default_nettype wire
